// *** rtl/iqm_pkg.sv ***
package iqm_pkg;

  localparam int SMP_W      = 16;
  localparam int PH_W       = 32;
  localparam int LUT_AW     = 8;
  localparam int LUT_DEPTH  = 256;
  localparam int GAIN_W     = 16;
  localparam int GAIN_FRAC  = 14;
  localparam int HARM_W     = 4;
  localparam int NUM_OSC    = 8;
  localparam int OSC_SEL_W  = 3;
  localparam int NUM_SINE   = 4;
  localparam int SINE_SEL_W = 2;
  localparam int WAIT_W     = 32;

  localparam logic [SMP_W-1:0]  SMP_MAX    = 16'h7FFF;
  localparam logic [SMP_W-1:0]  SMP_MIN    = 16'h8000;
  localparam logic [PH_W-1:0]   PHASE_RST  = 32'h0000_0000;
  localparam logic [GAIN_W-1:0] GAIN_UNITY = 16'h4000;
  localparam logic [GAIN_W-1:0] GAIN_HALF  = 16'h2000;

  // sequencer period is about 3.33 ns, kept in picoseconds
  localparam int SEQ_PERIOD_PS = 3330;
  localparam int CORE_PERIOD_PS = 40000;
  // sequencer periods elapsed per core cycle, scaled by 2^16 (rounded down)
  localparam logic [31:0] WAIT_FRAC_INC = 32'((longint'(CORE_PERIOD_PS) * 65536) / SEQ_PERIOD_PS);

  typedef enum logic [1:0] {
    IQM_ROUTE_NONE  = 2'h0,
    IQM_ROUTE_OUT1  = 2'h1,
    IQM_ROUTE_BOTH  = 2'h3,
    IQM_ROUTE_OUT2  = 2'h2
  } iqm_route_t;

  typedef enum logic [1:0] {
    IQM_PS_IDLE    = 2'b00,
    IQM_PS_ARMED   = 2'b01,
    IQM_PS_APPLY   = 2'b11
  } iqm_pstate_t;

  typedef struct packed {
    logic                  mod_en;
    iqm_route_t            route;
    logic [SINE_SEL_W-1:0] sine_out1;
    logic [SINE_SEL_W-1:0] sine_out2;
    logic [GAIN_W-1:0]     gain_out1;
    logic [GAIN_W-1:0]     gain_out2;
  } iqm_chan_cfg_t;

  typedef struct packed {
    logic [OSC_SEL_W-1:0] osc_sel;
    logic [PH_W-1:0]      phase_ofs;
    logic [HARM_W-1:0]    harmonic;
  } iqm_sine_cfg_t;

  typedef struct packed {
    logic                  valid;
    logic [SINE_SEL_W-1:0] sine;
    logic [PH_W-1:0]       delta;
  } iqm_phase_step_t;

endpackage

// *** rtl/iqm_sine_gen.sv ***
`timescale 1ns/10ps
`default_nettype none
module iqm_sine_gen
  import iqm_pkg::*;
(
  input  wire logic                    core_clk_in,
  input  wire logic [PH_W-1:0]         osc_phase_in,
  input  wire logic [PH_W-1:0]         phase_ofs_in,
  input  wire logic [HARM_W-1:0]       harmonic_in,
  output logic signed [SMP_W-1:0]      sine_out
);

  logic signed [SMP_W-1:0] lut [LUT_DEPTH];
  logic [PH_W-1:0]         harm_phase;
  logic [PH_W-1:0]         tot_phase;
  logic [LUT_AW-1:0]       lut_addr;
  logic signed [SMP_W-1:0] sine_ff;

  // one full period, filled by elaboration-time constants
  initial begin
    for (int i = 0; i < LUT_DEPTH; i++) begin
      lut[i] = SMP_W'($rtoi(32767.0 * $sin(2.0 * 3.14159265358979 * i / LUT_DEPTH)));
    end
  end

  assign harm_phase = PH_W'(osc_phase_in * harmonic_in);
  assign tot_phase  = harm_phase + phase_ofs_in;
  assign lut_addr   = tot_phase[PH_W-1 -: LUT_AW];

  always_ff @(posedge core_clk_in) begin
    sine_ff <= lut[lut_addr];
  end

  assign sine_out = sine_ff;

endmodule
`default_nettype wire

// *** rtl/iqm_datapath.sv ***
// Behaviour
// - enabled channel envelope is multiplied by its chosen sine before output
// - oscillators keep advancing while playback is stopped
// - sine generator applies harmonic and phase offset, then one-period table lookup
// - oscillator is a phase accumulator adding a frequency word each cycle
// - each sine generator selects its feeding oscillator
// - channel routing names one sine per output port
// - diagonal routing uses only two multipliers
// - routing both channels to both outputs uses four multipliers, summed
// - crossed routing gives ch1*s1+ch2*s2 and ch1*s2+ch2*s1 per chosen sines
// - each multiplier has its own gain; software sets 0.5 when summing
// - wait counts are in sequencer periods of about 3.33 ns
// - routing may change during playback, no sequencer stop needed
// - gain, offset and phase adjust live without touching envelopes
// - in oscillator control mode a core may use only its four oscillators
// - sine phase step takes effect at end of preceding waveform playback
`timescale 1ns/10ps
`default_nettype none
module iqm_datapath
  import iqm_pkg::*;
(
  input  wire logic                       core_clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       core_idx_in,
  input  wire logic                       osc_ctrl_en_in,
  input  wire logic [NUM_OSC*PH_W-1:0]    osc_freq_in,
  input  wire iqm_sine_cfg_t [NUM_SINE-1:0] sine_cfg_in,
  input  wire iqm_chan_cfg_t [1:0]        chan_cfg_in,
  input  wire logic signed [SMP_W-1:0]    out1_offset_in,
  input  wire logic signed [SMP_W-1:0]    out2_offset_in,
  input  wire logic signed [SMP_W-1:0]    env1_in,
  input  wire logic signed [SMP_W-1:0]    env2_in,
  input  wire logic                       play_active_in,
  input  wire iqm_phase_step_t            phase_step_in,
  input  wire logic                       wait_start_in,
  input  wire logic [WAIT_W-1:0]          wait_count_in,
  output logic signed [SMP_W-1:0]         out1_out,
  output logic signed [SMP_W-1:0]         out2_out,
  output logic                            sat1_out,
  output logic                            sat2_out,
  output logic                            wait_busy_out,
  output logic                            phase_step_pending_out
);

  localparam int PROD_W = SMP_W + SMP_W + GAIN_W;
  localparam int SUM_W  = PROD_W + 2;

  function automatic logic signed [SMP_W-1:0] sat_to_sample(input logic signed [SUM_W-1:0] v);
    logic signed [SUM_W-1:0] hi;
    logic signed [SUM_W-1:0] lo;
    hi = SUM_W'($signed(SMP_MAX));
    lo = SUM_W'($signed(SMP_MIN));
    if (v > hi) begin
      return $signed(SMP_MAX);
    end else if (v < lo) begin
      return $signed(SMP_MIN);
    end
    return v[SMP_W-1:0];
  endfunction

  function automatic logic is_sat(input logic signed [SUM_W-1:0] v);
    return (v > SUM_W'($signed(SMP_MAX))) || (v < SUM_W'($signed(SMP_MIN)));
  endfunction

  // operands widened first so the triple product is formed at full width
  function automatic logic signed [PROD_W-1:0] mul_gain(input logic signed [SMP_W-1:0] e,
                                                         input logic signed [SMP_W-1:0] s,
                                                         input logic [GAIN_W-1:0]       g);
    logic signed [PROD_W-1:0] ew;
    logic signed [PROD_W-1:0] sw;
    logic signed [PROD_W-1:0] gw;
    ew = PROD_W'(e);
    sw = PROD_W'(s);
    gw = PROD_W'({1'b0, g});
    return ew * sw * gw;
  endfunction

  // scale product of sample*sine*gain back to sample range
  function automatic logic signed [SUM_W-1:0] scale_prod(input logic signed [PROD_W-1:0] p);
    return SUM_W'(p >>> (SMP_W - 1 + GAIN_FRAC));
  endfunction

  // ---------------- oscillators
  logic [PH_W-1:0] osc_ph_ff [NUM_OSC];

  // no dependence on play_active_in: carrier phase survives restarts
  always_ff @(posedge core_clk_in) begin
    for (int o = 0; o < NUM_OSC; o++) begin
      if (!rst_n_in) begin
        osc_ph_ff[o] <= PHASE_RST;
      end else begin
        osc_ph_ff[o] <= osc_ph_ff[o] + osc_freq_in[o*PH_W +: PH_W];
      end
    end
  end

  // ---------------- phase step state machine
  iqm_pstate_t          pst_ff;
  iqm_pstate_t          nxt_pst;
  logic                 play_d_ff;
  logic [SINE_SEL_W-1:0] step_sine_ff;
  logic [PH_W-1:0]      step_delta_ff;
  logic [PH_W-1:0]      step_acc_ff [NUM_SINE];
  wire                  play_end = play_d_ff && !play_active_in;

  always_comb begin
    nxt_pst = pst_ff;
    case (pst_ff)
      IQM_PS_IDLE: begin
        if (phase_step_in.valid) begin
          nxt_pst = IQM_PS_ARMED;
        end
      end
      IQM_PS_ARMED: begin
        if (play_end) begin
          nxt_pst = IQM_PS_APPLY;
        end
      end
      IQM_PS_APPLY: begin
        nxt_pst = IQM_PS_IDLE;
      end
      default: begin
        nxt_pst = IQM_PS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pst_ff        <= IQM_PS_IDLE;
      play_d_ff     <= 1'b0;
      step_sine_ff  <= '0;
      step_delta_ff <= PHASE_RST;
      for (int s = 0; s < NUM_SINE; s++) begin
        step_acc_ff[s] <= PHASE_RST;
      end
    end else begin
      pst_ff    <= nxt_pst;
      play_d_ff <= play_active_in;
      if (pst_ff == IQM_PS_IDLE && phase_step_in.valid) begin
        step_sine_ff  <= phase_step_in.sine;
        step_delta_ff <= phase_step_in.delta;
      end
      if (pst_ff == IQM_PS_APPLY) begin
        step_acc_ff[step_sine_ff] <= step_acc_ff[step_sine_ff] + step_delta_ff;
      end
    end
  end

  // ---------------- sine generators
  logic signed [SMP_W-1:0] sine_val [NUM_SINE];
  logic [OSC_SEL_W-1:0]    eff_osc [NUM_SINE];
  logic [PH_W-1:0]         sine_ofs [NUM_SINE];

  for (genvar g = 0; g < NUM_SINE; g++) begin : g_sine
    // restricted mode pins the upper select bit to this core's group of four
    assign eff_osc[g] = osc_ctrl_en_in ? {core_idx_in, sine_cfg_in[g].osc_sel[1:0]}
                                       : sine_cfg_in[g].osc_sel;
    assign sine_ofs[g] = sine_cfg_in[g].phase_ofs + step_acc_ff[g];
    iqm_sine_gen u_sine (
      .core_clk_in  (core_clk_in),
      .osc_phase_in (osc_ph_ff[eff_osc[g]]),
      .phase_ofs_in (sine_ofs[g]),
      .harmonic_in  (sine_cfg_in[g].harmonic),
      .sine_out     (sine_val[g])
    );
  end

  // ---------------- four multipliers
  // cfg is read every cycle, so routing and gain changes apply live
  logic signed [SMP_W-1:0]  env [2];
  logic signed [PROD_W-1:0] prod_ff [2][2];
  logic                     use_ff [2][2];
  logic                     use_w [2][2];
  logic signed [SMP_W-1:0]  sel_sine [2][2];
  logic [GAIN_W-1:0]        sel_gain [2][2];

  assign env[0] = env1_in;
  assign env[1] = env2_in;

  for (genvar c = 0; c < 2; c++) begin : g_chan
    assign sel_sine[c][0] = sine_val[chan_cfg_in[c].sine_out1];
    assign sel_sine[c][1] = sine_val[chan_cfg_in[c].sine_out2];
    assign sel_gain[c][0] = chan_cfg_in[c].gain_out1;
    assign sel_gain[c][1] = chan_cfg_in[c].gain_out2;
    assign use_w[c][0] = chan_cfg_in[c].route[0];
    assign use_w[c][1] = chan_cfg_in[c].route[1];
  end

  always_ff @(posedge core_clk_in) begin
    for (int c = 0; c < 2; c++) begin
      for (int p = 0; p < 2; p++) begin
        if (!rst_n_in) begin
          prod_ff[c][p] <= '0;
          use_ff[c][p]  <= 1'b0;
        end else begin
          use_ff[c][p] <= use_w[c][p];
          if (chan_cfg_in[c].mod_en) begin
            prod_ff[c][p] <= mul_gain(env[c], sel_sine[c][p], sel_gain[c][p]);
          end else begin
            // unmodulated: envelope scaled as if by a full-scale carrier
            prod_ff[c][p] <= mul_gain(env[c], $signed(SMP_MAX), sel_gain[c][p]);
          end
        end
      end
    end
  end

  // ---------------- summation per output port
  logic signed [SUM_W-1:0] sum [2];
  logic signed [SUM_W-1:0] ofs [2];
  assign ofs[0] = SUM_W'(out1_offset_in);
  assign ofs[1] = SUM_W'(out2_offset_in);

  for (genvar p = 0; p < 2; p++) begin : g_port
    assign sum[p] = ofs[p]
                  + (use_ff[0][p] ? scale_prod(prod_ff[0][p]) : SUM_W'(0))
                  + (use_ff[1][p] ? scale_prod(prod_ff[1][p]) : SUM_W'(0));
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      out1_out <= '0;
      out2_out <= '0;
      sat1_out <= 1'b0;
      sat2_out <= 1'b0;
    end else begin
      out1_out <= sat_to_sample(sum[0]);
      out2_out <= sat_to_sample(sum[1]);
      sat1_out <= is_sat(sum[0]);
      sat2_out <= is_sat(sum[1]);
    end
  end

  // ---------------- wait timer in sequencer periods
  logic [WAIT_W-1:0] wait_left_ff;
  logic [15:0]       wait_frac_ff;
  logic [31:0]       frac_sum;
  assign frac_sum = {16'h0000, wait_frac_ff} + WAIT_FRAC_INC;

  // each core cycle spans ~12 sequencer periods; fractional carry keeps it exact
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      wait_left_ff  <= '0;
      wait_frac_ff  <= 16'h0000;
      wait_busy_out <= 1'b0;
    end else if (wait_start_in) begin
      wait_left_ff  <= wait_count_in;
      wait_frac_ff  <= 16'h0000;
      wait_busy_out <= (wait_count_in != '0);
    end else if (wait_busy_out) begin
      wait_frac_ff <= frac_sum[15:0];
      if (wait_left_ff <= WAIT_W'(frac_sum[31:16])) begin
        wait_left_ff  <= '0;
        wait_busy_out <= 1'b0;
      end else begin
        wait_left_ff <= wait_left_ff - WAIT_W'(frac_sum[31:16]);
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      phase_step_pending_out <= 1'b0;
    end else begin
      phase_step_pending_out <= (nxt_pst != IQM_PS_IDLE);
    end
  end

endmodule
`default_nettype wire

// *** verification/iqm_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module iqm_checker
  import iqm_pkg::*;
(
  input wire logic                    core_clk_in,
  input wire logic                    rst_n_in,
  input wire iqm_chan_cfg_t [1:0]     chan_cfg_in,
  input wire logic signed [SMP_W-1:0] out1_offset_in,
  input wire logic                    play_active_in,
  input wire iqm_phase_step_t         phase_step_in,
  input wire logic                    wait_start_in,
  input wire logic signed [SMP_W-1:0] out1_out,
  input wire logic signed [SMP_W-1:0] out2_out,
  input wire logic                    sat1_out,
  input wire logic                    sat2_out,
  input wire logic                    wait_busy_out,
  input wire logic                    phase_step_pending_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // reset itself is the cause here, so this one is never disabled
  AST_RST_CLR: assert property (disable iff (1'h0) !rst_n_in |=> !out1_out && !out2_out && !wait_busy_out)
    else $error("outputs not cleared by reset");
  AST_SAT1_RAIL: assert property (sat1_out |-> out1_out == SMP_MAX || out1_out == SMP_MIN)
    else $error("out1 saturation flag off the rail");
  AST_SAT2_RAIL: assert property (sat2_out |-> out2_out == SMP_MAX || out2_out == SMP_MIN)
    else $error("out2 saturation flag off the rail");
  AST_ROUTE_NONE: assert property ((!chan_cfg_in[0].route[0] && !chan_cfg_in[1].route[0]
    && $stable(out1_offset_in)) [*3] |-> out1_out == out1_offset_in)
    else $error("out1 not offset only while unrouted");
  AST_WAIT_RISE: assert property (wait_start_in && !wait_busy_out |=> wait_busy_out)
    else $error("wait did not start");
  AST_WAIT_IDLE: assert property (!wait_start_in && !wait_busy_out |=> !wait_busy_out)
    else $error("wait busy without a start");
  AST_PEND_SET: assert property (phase_step_in.valid && !phase_step_pending_out |=> phase_step_pending_out)
    else $error("phase step not armed");
  AST_PEND_HOLD: assert property (phase_step_pending_out && play_active_in && $past(play_active_in) |=> phase_step_pending_out)
    else $error("phase step applied during playback");
  AST_PEND_CLR: assert property (phase_step_pending_out && $fell(play_active_in) |-> ##[1:2] !phase_step_pending_out)
    else $error("phase step not applied after playback end");
  AST_PEND_IDLE: assert property (!phase_step_pending_out && !phase_step_in.valid |=> !phase_step_pending_out)
    else $error("phase step armed without request");
endmodule
bind iqm_datapath iqm_checker chk_i (.core_clk_in, .rst_n_in, .chan_cfg_in, .out1_offset_in, .play_active_in,
  .phase_step_in, .wait_start_in, .out1_out, .out2_out, .sat1_out, .sat2_out, .wait_busy_out,
  .phase_step_pending_out);
`default_nettype wire

// *** verification/iqm_env_src.sv ***
`timescale 1ns/10ps
`default_nettype none
module iqm_env_src
  import iqm_pkg::*;
(
  input  wire logic               core_clk_in,
  output logic signed [SMP_W-1:0] env1_out,
  output logic signed [SMP_W-1:0] env2_out,
  output logic                    play_out
);
  initial begin
    env1_out = '0;
    env2_out = '0;
    play_out = 1'h0;
  end
  task automatic start(input logic [SMP_W-1:0] e1, input logic [SMP_W-1:0] e2);
    @(posedge core_clk_in);
    env1_out <= e1;
    env2_out <= e2;
    play_out <= 1'h1;
  endtask
  // a stopped core plays silence, so only the oscillators can carry phase over the gap
  task automatic stop();
    @(posedge core_clk_in);
    env1_out <= '0;
    env2_out <= '0;
    play_out <= 1'h0;
  endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import iqm_pkg::*;
;
  logic                         core_clk_in = 1'h0;
  logic                         rst_n_in = 1'h0;
  logic                         core_idx_in = 1'h0;
  logic                         osc_ctrl_en_in = 1'h0;
  logic                         wait_start_in = 1'h0;
  logic [NUM_OSC*PH_W-1:0]      osc_freq_in = '0;
  iqm_sine_cfg_t [NUM_SINE-1:0] sine_cfg_in = '0;
  iqm_chan_cfg_t [1:0]          chan_cfg_in = '0;
  iqm_phase_step_t              phase_step_in = '0;
  logic [WAIT_W-1:0]            wait_count_in = '0;
  logic signed [SMP_W-1:0]      out1_offset_in = '0;
  logic signed [SMP_W-1:0]      out2_offset_in = '0;
  logic signed [SMP_W-1:0]      env1_in, env2_in, out1_out, out2_out, v0, v1;
  logic                         play_active_in, sat1_out, sat2_out, wait_busy_out, phase_step_pending_out;
  int                           err_count = 0;
  int                           check_count = 0;
  int                           n;
  always #20 core_clk_in = ~core_clk_in;
  iqm_env_src src (.core_clk_in, .env1_out(env1_in), .env2_out(env2_in), .play_out(play_active_in));
  iqm_datapath dut (.core_clk_in, .rst_n_in, .core_idx_in, .osc_ctrl_en_in, .osc_freq_in, .sine_cfg_in,
    .chan_cfg_in, .out1_offset_in, .out2_offset_in, .env1_in, .env2_in, .play_active_in, .phase_step_in,
    .wait_start_in, .wait_count_in, .out1_out, .out2_out, .sat1_out, .sat2_out, .wait_busy_out,
    .phase_step_pending_out);
  task automatic chk(input string what, input logic [SMP_W-1:0] seen, input logic [SMP_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk_in);
    #1;
  endtask
  task automatic route(input int c, input logic m, input iqm_route_t r, input int s1, input int s2,
                       input logic [GAIN_W-1:0] g1, input logic [GAIN_W-1:0] g2);
    chan_cfg_in[c] <= '{m, r, s1[1:0], s2[1:0], g1, g2};
  endtask
  task automatic sine(input int s, input int o, input logic [PH_W-1:0] p, input int h);
    sine_cfg_in[s] <= '{o[2:0], p, h[3:0]};
  endtask
  initial begin
    #100000;
    err_count++;
    give_verdict();
  end
  initial begin
    for (int i = 0; i < NUM_SINE; i++) sine_cfg_in[i].harmonic = 4'h1;
    repeat (10) @(posedge core_clk_in);
    rst_n_in <= 1'h1;
    out1_offset_in <= 16'h0123;
    out2_offset_in <= 16'hFF00;
    cyc(4);
    chk("out1 unrouted", out1_out, 16'h0123);
    chk("out2 unrouted", out2_out, 16'hFF00);
    src.start(16'h4000, 16'h4000);
    route(0, 1'h1, IQM_ROUTE_OUT1, 0, 1, GAIN_UNITY, GAIN_UNITY);
    route(1, 1'h1, IQM_ROUTE_OUT2, 1, 1, GAIN_UNITY, GAIN_UNITY);
    sine(1, 0, 32'h4000_0000, 1);
    cyc(4);
    chk("diag out1", out1_out, 16'h0123);
    chk("diag out2", 16'(out2_out > 0), 16'h1);
    @(posedge core_clk_in);
    route(0, 1'h1, IQM_ROUTE_BOTH, 0, 1, GAIN_HALF, GAIN_HALF);
    route(1, 1'h1, IQM_ROUTE_BOTH, 1, 0, GAIN_HALF, GAIN_HALF);
    sine(0, 0, 32'h4000_0000, 1);
    sine(1, 0, 32'hC000_0000, 1);
    src.start(16'h4000, 16'hC000);
    cyc(4);
    chk("cross out1", 16'(out1_out > 0), 16'h1);
    chk("cross out2", 16'(out2_out < 0), 16'h1);
    @(posedge core_clk_in);
    route(0, 1'h0, IQM_ROUTE_BOTH, 0, 0, 16'h0000, GAIN_UNITY);
    route(1, 1'h0, IQM_ROUTE_NONE, 0, 0, GAIN_UNITY, GAIN_UNITY);
    cyc(4);
    chk("zero gain", out1_out, 16'h0123);
    chk("unity gain", 16'(out2_out > 0), 16'h1);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk_in);
      route(1, 1'h0, IQM_ROUTE_BOTH, 0, 0, GAIN_UNITY, GAIN_UNITY);
      chan_cfg_in[0].gain_out1 <= GAIN_UNITY;
      out1_offset_in <= i ? SMP_MIN : SMP_MAX;
      src.start(i ? 16'h8000 : 16'h7FFF, i ? 16'h8000 : 16'h7FFF);
      cyc(4);
      chk("clipped out1", out1_out, i ? SMP_MIN : SMP_MAX);
      chk("clip flag", {15'h0000, sat1_out}, 16'h0001);
      chk("clipped out2", out2_out, i ? SMP_MIN : SMP_MAX);
      chk("clip flag 2", {15'h0000, sat2_out}, 16'h0001);
    end
    // quarter-turn carrier: samples alternate between zero and a peak
    @(posedge core_clk_in);
    osc_freq_in[PH_W +: PH_W] <= 32'h4000_0000;
    out1_offset_in <= '0;
    sine(0, 1, '0, 1);
    route(0, 1'h1, IQM_ROUTE_OUT1, 0, 0, GAIN_UNITY, GAIN_UNITY);
    route(1, 1'h0, IQM_ROUTE_NONE, 0, 0, GAIN_UNITY, GAIN_UNITY);
    src.start(16'h4000, 16'h4000);
    cyc(4);
    v0 = out1_out;
    cyc(1);
    v1 = out1_out;
    chk("quarter step", 16'((v0 == 0) ^ (v1 == 0)), 16'h1);
    src.stop();
    repeat (2) @(posedge core_clk_in);
    src.start(16'h4000, 16'h4000);
    cyc(7);
    chk("coherent a", out1_out, v0);
    cyc(1);
    chk("coherent b", out1_out, v1);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk_in);
      osc_ctrl_en_in <= 1'h1;
      core_idx_in <= i[0];
      cyc(4);
      v0 = out1_out;
      cyc(1);
      chk("osc group", 16'((v0 != 0) || (out1_out != 0)), 16'(i == 0));
    end
    @(posedge core_clk_in);
    wait_start_in <= 1'h1;
    wait_count_in <= 32'h0000_04B0;
    @(posedge core_clk_in);
    wait_start_in <= 1'h0;
    n = 0;
    cyc(1);
    while (wait_busy_out === 1'h1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk("wait span", 16'(n >= 97 && n <= 103), 16'h1);
    if (n >= 200) give_verdict();
    // second request lands while the first is pending and must be dropped
    @(posedge core_clk_in);
    osc_ctrl_en_in <= 1'h0;
    sine(0, 2, '0, 1);
    phase_step_in <= '{1'h1, 2'h0, 32'h4000_0000};
    repeat (2) @(posedge core_clk_in);
    phase_step_in <= '0;
    cyc(4);
    chk("step pending", {15'h0000, phase_step_pending_out}, 16'h0001);
    chk("step deferred", out1_out, 16'h0000);
    src.stop();
    cyc(4);
    chk("step applied", {15'h0000, phase_step_pending_out}, 16'h0000);
    src.start(16'h4000, 16'h4000);
    cyc(4);
    chk("single step", 16'(out1_out > 0), 16'h1);
    @(posedge core_clk_in);
    // running oscillator, harmonic zero: only the offset (plus the step) sets the phase
    sine(0, 1, 32'hC000_0000, 0);
    cyc(4);
    chk("harmonic zero", out1_out, 16'h0000);
    cyc(1);
    chk("harmonic zero b", out1_out, 16'h0000);
    give_verdict();
  end
endmodule
`default_nettype wire
